// ---- hw/hbfs_pkg.sv ----
// Shared constants and carrier types for the half-bridge fault supervisor.
// Assumes a single 20 MHz clock domain and a plain strobed register port.
package hbfs_pkg;
   localparam int HBFS_NUM_HB = 6;
   localparam int HBFS_ADDR_W = 4;
   localparam int HBFS_DATA_W = 8;
   localparam int HBFS_CLK_MHZ = 20;
   // Filter and dead times in nanoseconds; plain defaults, the analog figures vary by part.
   localparam int HBFS_OC_FILT_NS = 10000;
   localparam int HBFS_OL_FILT_NS = 200000;
   localparam int HBFS_OL_FILT_LED_NS = 50000;
   localparam int HBFS_DEAD_HL_NS = 500;
   localparam int HBFS_DEAD_LH_NS = 500;
   // Least times round up to whole cycles.
   localparam int HBFS_OC_FILT_CYC = (HBFS_OC_FILT_NS * HBFS_CLK_MHZ + 999) / 1000;
   localparam int HBFS_OL_FILT_CYC = (HBFS_OL_FILT_NS * HBFS_CLK_MHZ + 999) / 1000;
   localparam int HBFS_OL_LED_CYC = (HBFS_OL_FILT_LED_NS * HBFS_CLK_MHZ + 999) / 1000;
   localparam int HBFS_DEAD_HL_CYC = (HBFS_DEAD_HL_NS * HBFS_CLK_MHZ + 999) / 1000;
   localparam int HBFS_DEAD_LH_CYC = (HBFS_DEAD_LH_NS * HBFS_CLK_MHZ + 999) / 1000;
   localparam int HBFS_CNT_W = 16;
   // Register indices.
   localparam logic [3:0] HBFS_REG_GLOBAL = 4'h0;
   localparam logic [3:0] HBFS_REG_OC_HIGH = 4'h1;
   localparam logic [3:0] HBFS_REG_OC_LOW = 4'h2;
   localparam logic [3:0] HBFS_REG_OL_HIGH = 4'h3;
   localparam logic [3:0] HBFS_REG_OL_LOW = 4'h4;
   localparam logic [3:0] HBFS_REG_EN_HIGH = 4'h5;
   localparam logic [3:0] HBFS_REG_EN_LOW = 4'h6;
   localparam logic [3:0] HBFS_REG_FW_OL = 4'h7;
   // Global status byte fields.
   localparam int HBFS_GS_TPW = 1;
   localparam int HBFS_GS_TSD = 2;
   localparam int HBFS_GS_NEGATED_POWER_ON_RESET_FLAG = 3;
   localparam int HBFS_GS_OV = 4;
   localparam int HBFS_GS_UV = 5;
   localparam int HBFS_GS_LE = 6;
   // Freewheel/open-load config fields.
   localparam int HBFS_FW_LED_A = 6;
   localparam int HBFS_FW_LED_B = 7;

   typedef struct packed {
      logic [HBFS_ADDR_W-1:0] addr;
      logic [HBFS_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } hbfs_bus_t;

   typedef struct packed {
      logic [HBFS_NUM_HB-1:0] oc_high;
      logic [HBFS_NUM_HB-1:0] oc_low;
      logic [HBFS_NUM_HB-1:0] ul_high;
      logic [HBFS_NUM_HB-1:0] ul_low;
      logic temp_warn;
      logic temp_sd;
      logic supply_uv;
      logic supply_ov;
      logic enable_pin;
   } hbfs_sense_t;

   typedef struct packed {
      logic [HBFS_NUM_HB-1:0] high_on;
      logic [HBFS_NUM_HB-1:0] low_on;
   } hbfs_gate_t;
endpackage : hbfs_pkg

// ---- hw/hbfs_leg.sv ----
// One half-bridge leg: dead-time interlock between its high and low switch.
// Assumes the requests are already gated by every fault and lockout.
`timescale 1ns/1ps
module hbfs_leg #(
   parameter int DEAD_HL = hbfs_pkg::HBFS_DEAD_HL_CYC,
   parameter int DEAD_LH = hbfs_pkg::HBFS_DEAD_LH_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic high_req_in,
   input wire logic low_req_in,
   output logic high_on_out,
   output logic low_on_out
);
   import hbfs_pkg::*;

   typedef struct packed {
      logic high_on;
      logic low_on;
      logic [HBFS_CNT_W-1:0] dead;
   } hbfs_leg_state_t;

   hbfs_leg_state_t st_r;
   hbfs_leg_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // A request for both switches at once drives neither.
      // A switch that drops out of this leg always starts a dead time, so that
      // a later request for the other switch still waits for it.
      if (high_req_in == low_req_in) begin
         st_nxt.high_on = 1'b0;
         st_nxt.low_on = 1'b0;
         if (st_r.high_on) begin
            st_nxt.dead = HBFS_CNT_W'(DEAD_HL);
         end else if (st_r.low_on) begin
            st_nxt.dead = HBFS_CNT_W'(DEAD_LH);
         end else if (st_r.dead != '0) begin
            st_nxt.dead = st_r.dead - 1'b1;
         end
      end else if (high_req_in) begin
         st_nxt.low_on = 1'b0;
         if (st_r.low_on) begin
            st_nxt.dead = HBFS_CNT_W'(DEAD_LH);
         end else if (st_r.dead != '0) begin
            st_nxt.dead = st_r.dead - 1'b1;
         end else begin
            st_nxt.high_on = 1'b1;
         end
      end else begin
         st_nxt.high_on = 1'b0;
         if (st_r.high_on) begin
            st_nxt.dead = HBFS_CNT_W'(DEAD_HL);
         end else if (st_r.dead != '0) begin
            st_nxt.dead = st_r.dead - 1'b1;
         end else begin
            st_nxt.low_on = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign high_on_out = st_r.high_on;
   assign low_on_out = st_r.low_on;

   a_never_both: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !(high_on_out && low_on_out)) else $error("Both switches of a leg on.");
   a_dead_gap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $fell(high_on_out) |-> !low_on_out [*2]) else $error("Dead time skipped.");
endmodule : hbfs_leg

// ---- hw/hbfs_top.sv ----
// Fault supervisor for six half-bridges: overcurrent, open load, thermal,
// supply lockout, reset reporting and per-leg dead time. Sense inputs come
// from analog comparators, asynchronous to clk_in; registers use a strobe port.
`timescale 1ns/1ps
// Functional notes
// - Overcurrent held past the filter time latches the switch off and flags it.
// - Any overcurrent flag also sets the load-error summary bit.
// - An overcurrent-latched switch stays off while its flag is set.
// - High and low switch of a leg are never on together.
// - A dead time separates turning one switch off and the other on.
// - Thermal warning latches a flag; outputs keep running.
// - Thermal shutdown latches all outputs off until its flag is cleared.
// - Supply undervoltage turns outputs off and latches its flag; state kept.
// - Outputs return by themselves when undervoltage ends; flag stays.
// - Supply overvoltage turns outputs off, latches flag, recovers automatically.
// - Logic-supply reset initializes everything and floats all outputs.
// - Reset releases once the logic supply is back.
// - After reset, with enable high, the not-reset bit reads zero.
// - Low current past the open-load filter time latches open-load and load error.
// - Open-load detection never changes the output state.
// - The first two high switches have a light-load open-load mode.
// - Open-load is blanked for switches acting as freewheel in PWM.
// - Flags are cleared only by software or by reset; the not-reset bit only by reset.
// - Load error is the OR of all open-load and overcurrent flags.
module hbfs_top #(
   parameter int NUM_HB = hbfs_pkg::HBFS_NUM_HB,
   parameter int OC_FILT = hbfs_pkg::HBFS_OC_FILT_CYC,
   parameter int OL_FILT = hbfs_pkg::HBFS_OL_FILT_CYC,
   parameter int OL_LED = hbfs_pkg::HBFS_OL_LED_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire hbfs_pkg::hbfs_bus_t bus_in,
   output logic [hbfs_pkg::HBFS_DATA_W-1:0] rdata_out,
   input wire hbfs_pkg::hbfs_sense_t sense_in,
   input wire logic [hbfs_pkg::HBFS_NUM_HB-1:0] freewheel_high_in,
   input wire logic [hbfs_pkg::HBFS_NUM_HB-1:0] freewheel_low_in,
   output hbfs_pkg::hbfs_gate_t gate_out,
   output logic [hbfs_pkg::HBFS_NUM_HB-1:0] bridge_float_out
);
   import hbfs_pkg::*;

   localparam int SW = 2 * NUM_HB;
   localparam int SENSE_W = $bits(hbfs_sense_t);

   typedef struct packed {
      logic [SENSE_W-1:0] s1;
      logic [SENSE_W-1:0] s2;
      logic [SENSE_W-1:0] s3;
      logic [SENSE_W-1:0] sense;
      logic [SW-1:0][HBFS_CNT_W-1:0] oc_cnt;
      logic [SW-1:0][HBFS_CNT_W-1:0] ol_cnt;
      logic [SW-1:0] oc_flag;
      logic [SW-1:0] ol_flag;
      logic [SW-1:0] enable;
      logic [HBFS_DATA_W-1:0] fw_cfg;
      logic thermal_warning_flag;
      logic thermal_shutdown_flag;
      logic uv;
      logic ov;
      logic negated_power_on_reset_flag;
      logic [HBFS_DATA_W-1:0] rdata;
   } hbfs_state_t;

   logic rst_s1_r;
   logic rst_s2_r;
   hbfs_state_t st_r;
   hbfs_state_t st_nxt;
   hbfs_sense_t sn;
   logic [SW-1:0] oc_now;
   logic [SW-1:0] ul_now;
   logic [SW-1:0] fw_now;
   logic [SW-1:0] drive;
   logic [SW-1:0] ol_limit_hit;
   logic [HBFS_DATA_W-1:0] gstat;
   logic le_bit;
   logic lockout;
   logic [NUM_HB-1:0] hi_on;
   logic [NUM_HB-1:0] lo_on;

   // Logic-supply reset is released through two flops; the rest uses the copy.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   assign sn = hbfs_sense_t'(st_r.sense);
   // Switch index k: bits [NUM_HB-1:0] are high switches, the rest low switches.
   assign oc_now = {sn.oc_low, sn.oc_high};
   assign ul_now = {sn.ul_low, sn.ul_high};
   assign fw_now = {freewheel_low_in, freewheel_high_in};
   assign le_bit = |{st_r.oc_flag, st_r.ol_flag};
   assign lockout = st_r.thermal_shutdown_flag || sn.supply_uv || sn.supply_ov;

   // Outputs need the enable bit and no latched or live lockout; enables are untouched.
   assign drive = st_r.enable & ~st_r.oc_flag & {SW{!lockout}};

   always_comb begin
      gstat = '0;
      gstat[HBFS_GS_TPW] = st_r.thermal_warning_flag;
      gstat[HBFS_GS_TSD] = st_r.thermal_shutdown_flag;
      gstat[HBFS_GS_NEGATED_POWER_ON_RESET_FLAG] = st_r.negated_power_on_reset_flag;
      gstat[HBFS_GS_OV] = st_r.ov;
      gstat[HBFS_GS_UV] = st_r.uv;
      gstat[HBFS_GS_LE] = le_bit;
   end

   genvar k;
   generate
      for (k = 0; k < SW; k = k + 1) begin : g_lim
         // Light-load mode uses the shorter filter on the first two high switches.
         if (k == 0 || k == 1) begin : g_led
            localparam int LED_BIT = (k == 0) ? HBFS_FW_LED_A : HBFS_FW_LED_B;
            assign ol_limit_hit[k] = st_r.fw_cfg[LED_BIT] ?
               (st_r.ol_cnt[k] >= HBFS_CNT_W'(OL_LED - 1)) :
               (st_r.ol_cnt[k] >= HBFS_CNT_W'(OL_FILT - 1));
         end else begin : g_std
            assign ol_limit_hit[k] = st_r.ol_cnt[k] >= HBFS_CNT_W'(OL_FILT - 1);
         end
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      // Sense inputs pass three flops; a change counts once stages two and three agree.
      st_nxt.s1 = sense_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.sense = st_r.s3;
      end
      for (int i = 0; i < SW; i++) begin
         // Overcurrent filter runs only on a driven switch; flag set wins over a clear.
         if (oc_now[i] && drive[i]) begin
            if (st_r.oc_cnt[i] >= HBFS_CNT_W'(OC_FILT - 1)) begin
               st_nxt.oc_flag[i] = 1'b1;
               st_nxt.oc_cnt[i] = '0;
            end else begin
               st_nxt.oc_cnt[i] = st_r.oc_cnt[i] + 1'b1;
            end
         end else begin
            st_nxt.oc_cnt[i] = '0;
         end
         // Open load is only judged on an active switch that is not freewheeling.
         if (ul_now[i] && drive[i] && !fw_now[i]) begin
            if (ol_limit_hit[i]) begin
               st_nxt.ol_flag[i] = 1'b1;
            end else begin
               st_nxt.ol_cnt[i] = st_r.ol_cnt[i] + 1'b1;
            end
         end else begin
            st_nxt.ol_cnt[i] = '0;
         end
      end
      // Register writes: a 1 written to a flag bit clears it, unless it newly sets now or its thermal or supply cause is live.
      if (bus_in.wr) begin
         case (bus_in.addr)
            HBFS_REG_GLOBAL: begin
               if (bus_in.wdata[HBFS_GS_TPW] && !sn.temp_warn) st_nxt.thermal_warning_flag = 1'b0;
               if (bus_in.wdata[HBFS_GS_TSD] && !sn.temp_sd) st_nxt.thermal_shutdown_flag = 1'b0;
               if (bus_in.wdata[HBFS_GS_OV] && !sn.supply_ov) st_nxt.ov = 1'b0;
               if (bus_in.wdata[HBFS_GS_UV] && !sn.supply_uv) st_nxt.uv = 1'b0;
            end
            HBFS_REG_OC_HIGH: st_nxt.oc_flag[NUM_HB-1:0] =
               st_nxt.oc_flag[NUM_HB-1:0] & ~bus_in.wdata[NUM_HB-1:0] |
               (st_nxt.oc_flag[NUM_HB-1:0] & ~st_r.oc_flag[NUM_HB-1:0]);
            HBFS_REG_OC_LOW: st_nxt.oc_flag[SW-1:NUM_HB] =
               st_nxt.oc_flag[SW-1:NUM_HB] & ~bus_in.wdata[NUM_HB-1:0] |
               (st_nxt.oc_flag[SW-1:NUM_HB] & ~st_r.oc_flag[SW-1:NUM_HB]);
            HBFS_REG_OL_HIGH: st_nxt.ol_flag[NUM_HB-1:0] =
               st_nxt.ol_flag[NUM_HB-1:0] & ~bus_in.wdata[NUM_HB-1:0] |
               (st_nxt.ol_flag[NUM_HB-1:0] & ~st_r.ol_flag[NUM_HB-1:0]);
            HBFS_REG_OL_LOW: st_nxt.ol_flag[SW-1:NUM_HB] =
               st_nxt.ol_flag[SW-1:NUM_HB] & ~bus_in.wdata[NUM_HB-1:0] |
               (st_nxt.ol_flag[SW-1:NUM_HB] & ~st_r.ol_flag[SW-1:NUM_HB]);
            HBFS_REG_EN_HIGH: st_nxt.enable[NUM_HB-1:0] = bus_in.wdata[NUM_HB-1:0];
            HBFS_REG_EN_LOW: st_nxt.enable[SW-1:NUM_HB] = bus_in.wdata[NUM_HB-1:0];
            HBFS_REG_FW_OL: st_nxt.fw_cfg = bus_in.wdata;
            default: ;
         endcase
      end
      // Sticky event flags; these sets come last so they win over a same-cycle clear.
      if (sn.temp_warn) st_nxt.thermal_warning_flag = 1'b1;
      if (sn.temp_sd) st_nxt.thermal_shutdown_flag = 1'b1;
      if (sn.supply_uv) st_nxt.uv = 1'b1;
      if (sn.supply_ov) st_nxt.ov = 1'b1;
      // The not-reset bit reads 0 after reset; software writing 1 with the enable pin high acknowledges it.
      if (bus_in.wr && bus_in.addr == HBFS_REG_GLOBAL && bus_in.wdata[HBFS_GS_NEGATED_POWER_ON_RESET_FLAG]
          && sn.enable_pin) begin
         st_nxt.negated_power_on_reset_flag = 1'b1;
      end
      st_nxt.rdata = '0;
      if (bus_in.rd) begin
         case (bus_in.addr)
            HBFS_REG_GLOBAL: st_nxt.rdata = gstat;
            HBFS_REG_OC_HIGH: st_nxt.rdata[NUM_HB-1:0] = st_r.oc_flag[NUM_HB-1:0];
            HBFS_REG_OC_LOW: st_nxt.rdata[NUM_HB-1:0] = st_r.oc_flag[SW-1:NUM_HB];
            HBFS_REG_OL_HIGH: st_nxt.rdata[NUM_HB-1:0] = st_r.ol_flag[NUM_HB-1:0];
            HBFS_REG_OL_LOW: st_nxt.rdata[NUM_HB-1:0] = st_r.ol_flag[SW-1:NUM_HB];
            HBFS_REG_EN_HIGH: st_nxt.rdata[NUM_HB-1:0] = st_r.enable[NUM_HB-1:0];
            HBFS_REG_EN_LOW: st_nxt.rdata[NUM_HB-1:0] = st_r.enable[SW-1:NUM_HB];
            HBFS_REG_FW_OL: st_nxt.rdata = st_r.fw_cfg;
            default: st_nxt.rdata = '0;
         endcase
      end
   end

   // Reset initializes every flag and control bit; negated_power_on_reset_flag starts at 0.
   always_ff @(posedge clk_in or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   generate
      for (k = 0; k < NUM_HB; k = k + 1) begin : g_leg
         hbfs_leg u_leg (
            .clk_in(clk_in),
            .rst_n_in(rst_s2_r),
            .high_req_in(drive[k]),
            .low_req_in(drive[k + NUM_HB]),
            .high_on_out(hi_on[k]),
            .low_on_out(lo_on[k])
         );
         // A leg with neither switch on is high impedance, also during reset.
         assign bridge_float_out[k] = !(hi_on[k] || lo_on[k]);
      end
   endgenerate

   assign gate_out.high_on = hi_on;
   assign gate_out.low_on = lo_on;
   assign rdata_out = st_r.rdata;

   a_oc_latch_off: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      st_r.oc_flag[0] |=> !gate_out.high_on[0]) else $error("Overcurrent switch on.");
   a_tsd_all_off: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      st_r.thermal_shutdown_flag |=> (gate_out == '0)) else $error("Output on in thermal shutdown.");
   a_le_summary: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      gstat[HBFS_GS_LE] == (|{st_r.oc_flag, st_r.ol_flag})) else $error("Load error wrong.");
   a_tpw_sticky: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      st_r.thermal_warning_flag && !(bus_in.wr && bus_in.addr == HBFS_REG_GLOBAL) |=> st_r.thermal_warning_flag)
      else $error("Warning flag dropped.");
   a_uv_latch: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      sn.supply_uv |=> st_r.uv) else $error("Undervoltage flag missed.");
   a_ol_no_effect: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      $rose(st_r.ol_flag[0]) |-> drive[0]) else $error("Open load changed output.");
   a_enable_kept: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      !bus_in.wr |=> $stable(st_r.enable)) else $error("Enable altered by fault.");
   a_oc_filter: assert property (@(posedge clk_in) disable iff (!rst_s2_r)
      $rose(st_r.oc_flag[0]) |-> $past(oc_now[0])) else $error("Overcurrent unfiltered.");
endmodule : hbfs_top

// ---- tb/hbfs_mcu.sv ----
// Controller model: drives the register port and records expected reads.
// Assumes the bench compares read data one cycle after each read strobe.
`timescale 1ns/1ps
module hbfs_mcu (
   input wire logic clk_in,
   output hbfs_pkg::hbfs_bus_t bus_out
);
   import hbfs_pkg::*;
   logic [7:0] exp_q[$];
   initial bus_out = '0;
   // Flags clear by writing ones; a later read shows whether the cause remains.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus_out.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_in);
      bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus_out.rd <= 1'b0;
   endtask : rd
endmodule : hbfs_mcu

// ---- tb/hbfs_top_tb_top.sv ----
// Self-checking bench for the fault supervisor with shortened filter counts.
// Assumes the controller model above and sense levels driven directly.
`timescale 1ns/1ps
module hbfs_top_tb_top;
   import hbfs_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   hbfs_bus_t bus;
   logic [7:0] rdata;
   hbfs_sense_t sense;
   logic [5:0] fw_h;
   logic [5:0] fw_l;
   logic [5:0] flt;
   hbfs_gate_t gate;
   logic rd_d = 1'b0;
   logic [31:0] seed = 32'h7db1;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [7:0] fb[4] = '{8'h02, 8'h04, 8'h20, 8'h10};
   logic [31:0] r;
   always #25 clk_in = ~clk_in;
   hbfs_top #(.OC_FILT(4), .OL_FILT(8), .OL_LED(3)) dut_u (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .bus_in(bus),
      .rdata_out(rdata),
      .sense_in(sense),
      .freewheel_high_in(fw_h),
      .freewheel_low_in(fw_l),
      .gate_out(gate),
      .bridge_float_out(flt)
   );
   hbfs_mcu mcu_u (
      .clk_in(clk_in),
      .bus_out(bus)
   );
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic fail(input string m);
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
   endtask : fail
   task automatic chk_rd(input logic [7:0] e);
      checks_done++;
      if (rdata !== e) fail($sformatf("read %h exp %h", rdata, e));
   endtask : chk_rd
   task automatic chk_gate(input logic [5:0] h, input logic [5:0] l);
      checks_done++;
      if (gate.high_on !== h || gate.low_on !== l || flt !== ~(h | l))
         fail($sformatf("gate %h/%h exp %h/%h", gate.high_on, gate.low_on, h, l));
   endtask : chk_gate
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : settle
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   // Reads are judged in the single cycle where the data stand.
   always @(posedge clk_in) begin
      rd_d <= bus.rd;
      if (rd_d) chk_rd(mcu_u.exp_q.pop_front());
      if ((gate.high_on & gate.low_on) !== 6'h00) fail("cross conduction");
   end
   initial begin
      #(4000 * 50);
      fail("timeout");
      summarize();
   end
   initial begin
      sense = '0;
      sense.enable_pin = 1'b1;
      fw_h = '0;
      fw_l = '0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      settle(4);
      chk_gate(6'h00, 6'h00);
      mcu_u.rd(HBFS_REG_GLOBAL, 8'h00);
      mcu_u.wr(HBFS_REG_GLOBAL, 8'h08);
      mcu_u.rd(HBFS_REG_GLOBAL, 8'h08);
      mcu_u.wr(HBFS_REG_EN_HIGH, 8'h01);
      mcu_u.wr(HBFS_REG_EN_LOW, 8'h02);
      settle(30);
      chk_gate(6'h01, 6'h02);
      @(posedge clk_in);
      sense.oc_high[0] <= 1'b1;
      settle(30);
      chk_gate(6'h00, 6'h02);
      mcu_u.rd(HBFS_REG_OC_HIGH, 8'h01);
      mcu_u.rd(HBFS_REG_GLOBAL, 8'h48);
      @(posedge clk_in);
      sense.oc_high[0] <= 1'b0;
      settle(30);
      chk_gate(6'h00, 6'h02);
      mcu_u.rd(HBFS_REG_OC_HIGH, 8'h01);
      mcu_u.rd(HBFS_REG_EN_HIGH, 8'h01);
      mcu_u.wr(HBFS_REG_OC_HIGH, 8'h01);
      settle(30);
      chk_gate(6'h01, 6'h02);
      mcu_u.rd(HBFS_REG_GLOBAL, 8'h08);
      @(posedge clk_in);
      sense.ul_low[1] <= 1'b1;
      settle(40);
      chk_gate(6'h01, 6'h02);
      mcu_u.rd(HBFS_REG_OL_LOW, 8'h02);
      mcu_u.rd(HBFS_REG_GLOBAL, 8'h48);
      mcu_u.wr(HBFS_REG_OL_LOW, 8'h02);
      mcu_u.rd(HBFS_REG_OL_LOW, 8'h02);
      @(posedge clk_in);
      sense.ul_low[1] <= 1'b0;
      settle(10);
      mcu_u.wr(HBFS_REG_OL_LOW, 8'h02);
      mcu_u.rd(HBFS_REG_OL_LOW, 8'h00);
      @(posedge clk_in);
      fw_l <= 6'h02;
      sense.ul_low[1] <= 1'b1;
      settle(40);
      mcu_u.rd(HBFS_REG_OL_LOW, 8'h00);
      @(posedge clk_in);
      fw_l <= 6'h00;
      sense.ul_low[1] <= 1'b0;
      // Warning, shutdown, undervoltage, overvoltage in turn.
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_in);
         sense[4:1] <= 4'h8 >> k;
         settle(30);
         chk_gate(k ? 6'h00 : 6'h01, k ? 6'h00 : 6'h02);
         @(posedge clk_in);
         sense[4:1] <= 4'h0;
         settle(30);
         chk_gate(k == 1 ? 6'h00 : 6'h01, k == 1 ? 6'h00 : 6'h02);
         mcu_u.rd(HBFS_REG_GLOBAL, 8'h08 | fb[k]);
         mcu_u.wr(HBFS_REG_GLOBAL, fb[k]);
         settle(30);
         chk_gate(6'h01, 6'h02);
         mcu_u.rd(HBFS_REG_GLOBAL, 8'h08);
      end
      mcu_u.wr(HBFS_REG_EN_LOW, 8'h00);
      mcu_u.wr(HBFS_REG_EN_HIGH, 8'h03);
      settle(2);
      chk_gate(6'h01, 6'h00);
      settle(30);
      chk_gate(6'h03, 6'h00);
      mcu_u.wr(HBFS_REG_EN_HIGH, 8'h02);
      mcu_u.wr(HBFS_REG_EN_LOW, 8'h01);
      settle(2);
      chk_gate(6'h02, 6'h00);
      settle(30);
      chk_gate(6'h02, 6'h01);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         mcu_u.wr(HBFS_REG_EN_HIGH, {2'b00, r[5:0]});
         mcu_u.wr(HBFS_REG_EN_LOW, {2'b00, r[11:6] & ~r[5:0]});
         settle(30);
         chk_gate(r[5:0], r[11:6] & ~r[5:0]);
         mcu_u.rd(HBFS_REG_EN_HIGH, {2'b00, r[5:0]});
      end
      mcu_u.wr(HBFS_REG_FW_OL, 8'hc0);
      mcu_u.rd(HBFS_REG_FW_OL, 8'hc0);
      mcu_u.wr(4'hf, 8'hff);
      mcu_u.rd(4'hf, 8'h00);
      mcu_u.rd(HBFS_REG_GLOBAL, 8'h08);
      settle(3);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      settle(1);
      chk_gate(6'h00, 6'h00);
      summarize();
   end
endmodule : hbfs_top_tb_top
